// ---- bench/pmei_pin_model.sv ----
// External equipment on one 4-bit port: drives, pulls or floats each pin.
// Assumes the device's own drive wins over the equipment on a clash.
`timescale 1ns/1ns
`default_nettype none
module pmei_pin_model (
  // Clock
  input wire logic clk_in,
  // Device side
  input wire logic [3:0] dev_out_in,
  input wire logic [3:0] dev_oe_in,
  input wire logic [3:0] pullup_en_in,
  input wire logic [3:0] pulldn_en_in,
  // Equipment side
  input wire logic [3:0] ext_val_in,
  input wire logic [3:0] ext_en_in,
  output logic [3:0] level_out
);
  // Floating pins wander so a stale level is never trusted
  logic [3:0] float_r = 4'h5;
  always @(posedge clk_in) float_r <= ~float_r;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (dev_oe_in[i]) level_out[i] = dev_out_in[i];
      else if (ext_en_in[i]) level_out[i] = ext_val_in[i];
      else if (pullup_en_in[i]) level_out[i] = 1'b1;
      else if (pulldn_en_in[i]) level_out[i] = 1'b0;
      else level_out[i] = float_r[i];
    end
  end
endmodule
`default_nettype wire

// ---- bench/pmei_top_properties.sv ----
// Checker for the port block top: bus, shared word shadow, ext1 timing.
// Assumes it is bound onto pmei_top and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module pmei_top_properties #(
  parameter int unsigned TB_PERIOD_CYC = 16
) (
  // Clock, reset and bus
  input wire logic REF_CLK_IN,
  input wire logic RST_IN,
  input wire logic [7:0] SFR_ADDR_IN,
  input wire logic SFR_WR_IN,
  input wire logic SFR_RD_IN,
  input wire logic [3:0] SFR_WDATA_IN,
  input wire logic [3:0] SFR_RDATA_OUT,
  // Pins
  input wire logic [3:0] IN_PORT_PIN_IN,
  input wire logic IN_PORT_PULLUP_EN_OUT,
  input wire logic IN_PORT_PULLDN_EN_OUT,
  input wire logic [3:0] OUT_PORT_PIN_OUT,
  input wire logic [3:0] OUT_PORT_OE_OUT,
  input wire logic [3:0] BIDIR_A_PULLUP_EN_OUT,
  input wire logic [3:0] BIDIR_A_PULLDN_EN_OUT,
  // Interrupt
  input wire logic EXT1_IRQ_SIGNAL_OUT,
  input wire logic EXT1_IRQ_FLAG_OUT,
  input wire logic [11:0] EXT1_VECTOR_OUT
);
  // Shadow of the shared word, which cannot be read back
  logic [3:0] cfg_r, cfg_nxt;
  int unsigned cnt_r, cnt_nxt;
  logic tick_w;
  assign tick_w = (cnt_r == TB_PERIOD_CYC - 1);
  always_comb begin
    cfg_nxt = (SFR_WR_IN && SFR_ADDR_IN == 8'h1c) ? SFR_WDATA_IN : cfg_r;
    cnt_nxt = tick_w ? 32'h0 : cnt_r + 32'h1;
  end
  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      cfg_r <= 4'h0;
      cnt_r <= 32'h0;
    end else begin
      cfg_r <= cfg_nxt;
      cnt_r <= cnt_nxt;
    end
  end
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (RST_IN);
  cfg_no_read_a: assert property (SFR_RD_IN && SFR_ADDR_IN[7:4] == 4'h1 |=> SFR_RDATA_OUT == 4'h0)
    else $error("config word read back not zero");
  in_pull_a: assert property (IN_PORT_PULLUP_EN_OUT == (!cfg_r[0] && !cfg_r[2])
    && IN_PORT_PULLDN_EN_OUT == (!cfg_r[0] && cfg_r[2])) else $error("input port pull enables wrong");
  shared_pull_a: assert property (!(|BIDIR_A_PULLUP_EN_OUT && cfg_r[2])
    && !(|BIDIR_A_PULLDN_EN_OUT && !cfg_r[2])) else $error("bidir pull direction differs");
  out_drive_a: assert property (OUT_PORT_OE_OUT == (cfg_r[1] ? ~OUT_PORT_PIN_OUT : 4'hf))
    else $error("output port drive enable wrong");
  out_write_a: assert property (SFR_WR_IN && SFR_ADDR_IN == 8'h04
    |=> OUT_PORT_PIN_OUT == $past(SFR_WDATA_IN)) else $error("output port write not on pins");
  // Pins held for three samples so the two-stage synchroniser has settled
  in_level_a: assert property (SFR_RD_IN && SFR_ADDR_IN == 8'h03 && $stable(IN_PORT_PIN_IN)
    && IN_PORT_PIN_IN == $past(IN_PORT_PIN_IN, 2) |=> SFR_RDATA_OUT == $past(IN_PORT_PIN_IN))
    else $error("input level read wrong");
  irq_tick_a: assert property (EXT1_IRQ_SIGNAL_OUT |-> $past(tick_w))
    else $error("ext1 event away from sampling tick");
  irq_pulse_a: assert property ($rose(EXT1_IRQ_SIGNAL_OUT) |=> !EXT1_IRQ_SIGNAL_OUT)
    else $error("ext1 event longer than one cycle");
  irq_flag_a: assert property (EXT1_IRQ_SIGNAL_OUT |=> EXT1_IRQ_FLAG_OUT)
    else $error("ext1 flag not set after event");
  vector_a: assert property (EXT1_VECTOR_OUT == 12'h032)
    else $error("ext1 vector wrong");
endmodule
bind pmei_top pmei_top_properties #(.TB_PERIOD_CYC(TB_PERIOD_CYC)) chk_u (.REF_CLK_IN(REF_CLK_IN),
  .RST_IN(RST_IN), .SFR_ADDR_IN(SFR_ADDR_IN), .SFR_WR_IN(SFR_WR_IN), .SFR_RD_IN(SFR_RD_IN),
  .SFR_WDATA_IN(SFR_WDATA_IN), .SFR_RDATA_OUT(SFR_RDATA_OUT), .IN_PORT_PIN_IN(IN_PORT_PIN_IN),
  .IN_PORT_PULLUP_EN_OUT(IN_PORT_PULLUP_EN_OUT), .IN_PORT_PULLDN_EN_OUT(IN_PORT_PULLDN_EN_OUT),
  .OUT_PORT_PIN_OUT(OUT_PORT_PIN_OUT), .OUT_PORT_OE_OUT(OUT_PORT_OE_OUT),
  .BIDIR_A_PULLUP_EN_OUT(BIDIR_A_PULLUP_EN_OUT), .BIDIR_A_PULLDN_EN_OUT(BIDIR_A_PULLDN_EN_OUT),
  .EXT1_IRQ_SIGNAL_OUT(EXT1_IRQ_SIGNAL_OUT), .EXT1_IRQ_FLAG_OUT(EXT1_IRQ_FLAG_OUT),
  .EXT1_VECTOR_OUT(EXT1_VECTOR_OUT));
`default_nettype wire

// ---- bench/pmei_top_tb_top.sv ----
// Self-checking bench for the port block: registers, pins, ext1 and bidir events.
// Assumes a shortened time-base period; pin models stand at the input port and the three bidirectional ports.
`timescale 1ns/1ns
`default_nettype none
module pmei_top_tb_top;
  localparam int unsigned P = 16;
  localparam logic [3:0] EV_VAL [2][4] = '{'{4'hb, 4'h0, 4'h1, 4'hf}, '{4'h7, 4'h0, 4'h2, 4'hf}};
  localparam logic EV_EXP [2][4] = '{'{1'b1, 1'b0, 1'b0, 1'b1}, '{1'b0, 1'b1, 1'b1, 1'b0}};
  logic clk, rst, wr, rd, e_ack, b_ack, in_pu, in_pd, sig, flag, bflag;
  logic [7:0] addr;
  logic [3:0] wdata, rdata, out_pin, out_oe, in_val, in_en, a_val, a_en, b_val, b_en, c_val, c_en;
  logic [3:0] in_pin, a_pin, b_pin, c_pin, a_po, a_oe, a_pu, a_pd, b_po, b_oe, b_pu, b_pd, c_po, c_oe, c_pu, c_pd;
  logic [11:0] vec;
  integer seed = 93;
  int failures = 0;
  int checks = 0;
  int cyc = 0;
  pmei_top #(.TB_PERIOD_CYC(P)) dut_u (.REF_CLK_IN(clk), .RST_IN(rst), .SFR_ADDR_IN(addr), .SFR_WR_IN(wr),
    .SFR_RD_IN(rd), .SFR_WDATA_IN(wdata), .SFR_RDATA_OUT(rdata), .IN_PORT_PIN_IN(in_pin),
    .IN_PORT_PULLUP_EN_OUT(in_pu), .IN_PORT_PULLDN_EN_OUT(in_pd), .OUT_PORT_PIN_OUT(out_pin),
    .OUT_PORT_OE_OUT(out_oe), .BIDIR_A_PIN_IN(a_pin), .BIDIR_A_PIN_OUT(a_po), .BIDIR_A_OE_OUT(a_oe),
    .BIDIR_A_PULLUP_EN_OUT(a_pu), .BIDIR_A_PULLDN_EN_OUT(a_pd), .BIDIR_B_PIN_IN(b_pin), .BIDIR_B_PIN_OUT(b_po),
    .BIDIR_B_OE_OUT(b_oe), .BIDIR_B_PULLUP_EN_OUT(b_pu), .BIDIR_B_PULLDN_EN_OUT(b_pd), .BIDIR_C_PIN_IN(c_pin),
    .BIDIR_C_PIN_OUT(c_po), .BIDIR_C_OE_OUT(c_oe), .BIDIR_C_PULLUP_EN_OUT(c_pu), .BIDIR_C_PULLDN_EN_OUT(c_pd),
    .EXT1_IRQ_ACK_IN(e_ack), .BIDIR_IRQ_ACK_IN(b_ack), .EXT1_IRQ_SIGNAL_OUT(sig), .EXT1_IRQ_FLAG_OUT(flag),
    .EXT1_VECTOR_OUT(vec), .BIDIR_IRQ_FLAG_OUT(bflag));
  pmei_pin_model in_u (.clk_in(clk), .dev_out_in(4'h0), .dev_oe_in(4'h0), .pullup_en_in({4{in_pu}}),
    .pulldn_en_in({4{in_pd}}), .ext_val_in(in_val), .ext_en_in(in_en), .level_out(in_pin));
  pmei_pin_model a_u (.clk_in(clk), .dev_out_in(a_po), .dev_oe_in(a_oe), .pullup_en_in(a_pu),
    .pulldn_en_in(a_pd), .ext_val_in(a_val), .ext_en_in(a_en), .level_out(a_pin));
  pmei_pin_model b_u (.clk_in(clk), .dev_out_in(b_po), .dev_oe_in(b_oe), .pullup_en_in(b_pu),
    .pulldn_en_in(b_pd), .ext_val_in(b_val), .ext_en_in(b_en), .level_out(b_pin));
  pmei_pin_model c_u (.clk_in(clk), .dev_out_in(c_po), .dev_oe_in(c_oe), .pullup_en_in(c_pu),
    .pulldn_en_in(c_pd), .ext_val_in(c_val), .ext_en_in(c_en), .level_out(c_pin));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic wrap_up();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Hang guard; the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      failures++;
      wrap_up();
    end
  end
  task automatic cmp(input string nm, input logic [11:0] exp, input logic [11:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wrr(input logic [7:0] a, input logic [3:0] d);
    @(negedge clk);
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk);
    wr = 1'b0;
  endtask
  task automatic rdd(input logic [7:0] a, output logic [3:0] d);
    @(negedge clk);
    rd = 1'b1;
    addr = a;
    @(negedge clk);
    rd = 1'b0;
    d = rdata;
  endtask
  task automatic ack(input bit ext);
    @(negedge clk);
    if (ext) e_ack = 1'b1;
    else b_ack = 1'b1;
    @(negedge clk);
    e_ack = 1'b0;
    b_ack = 1'b0;
  endtask
  initial begin
    logic [3:0] d, v, dir, mod, got;
    logic [1:0] p;
    int cnt;
    rst = 1'b1;
    {wr, rd, e_ack, b_ack, addr, wdata} = '0;
    {in_val, in_en, a_val, a_en, b_val, b_en, c_val, c_en} = '0;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    cmp("in pullup", 12'h1, in_pu);
    cmp("out oe", 12'hf, out_oe);
    cmp("out data", 12'h0, out_pin);
    cmp("a pullup", 12'hf, a_pu);
    cmp("vector", 12'h032, vec);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      v = i[3:0];
      d = $random(seed);
      wrr(8'h04, d);
      wrr(8'h1c, v);
      cmp("in pullup", !v[0] && !v[2], in_pu);
      cmp("in pulldn", !v[0] && v[2], in_pd);
      cmp("a pulls", {{4{v[2]}}, {4{!v[2]}}}, {a_pd, a_pu});
      cmp("out oe", v[1] ? {~d} : 4'hf, out_oe);
      cmp("out data", d, out_pin);
      rdd(8'h1c, got);
      cmp("shared read", 12'h0, got);
      rdd(8'h04, got);
      cmp("out read", d, got);
    end
    $display("test shared config done");
    in_en = 4'hf;
    for (int i = 0; i < 4; i++) begin
      in_val = $random(seed);
      wrr(8'h03, ~in_val);
      repeat (3) @(negedge clk);
      rdd(8'h03, got);
      cmp("in level", in_val, got);
    end
    $display("test input level done");
    {a_en, b_en, c_en} = 12'hfff;
    for (int n = 0; n < 12; n++) begin
      p = 2'(n % 3);
      dir = $random(seed);
      mod = $random(seed);
      d = $random(seed);
      v = $random(seed);
      if (n < 4) dir = (n < 2) ? 4'hf : 4'h0;
      for (int i = 0; i < 4; i++) wrr(8'h10 + 8'h4 * p + i, {2'b00, dir[i], mod[i]});
      wrr({6'h0, p}, d);
      if (p[1]) c_val = v;
      else if (p[0]) b_val = v;
      else a_val = v;
      repeat (3) @(negedge clk);
      cmp("pin out", d, p[1] ? c_po : p[0] ? b_po : a_po);
      cmp("oe", dir & (~mod | ~d), p[1] ? c_oe : p[0] ? b_oe : a_oe);
      // Pull-down still selected by the last shared write
      cmp("pulls", {{~dir & ~mod}, 4'h0}, p[1] ? {c_pd, c_pu} : p[0] ? {b_pd, b_pu} : {a_pd, a_pu});
      rdd({6'h0, p}, got);
      cmp("data read", (dir & d) | (~dir & v), got);
    end
    $display("test bidir data done");
    a_val = 4'h0;
    wrr(8'h10, 4'hd);
    repeat (4) @(negedge clk);
    ack(1'b0);
    cmp("bidir flag idle", 12'h0, bflag);
    a_val = 4'h1;
    repeat (6) @(negedge clk);
    cmp("bidir flag", 12'h1, bflag);
    ack(1'b0);
    cmp("bidir flag ack", 12'h0, bflag);
    $display("test bidir event done");
    for (int k = 0; k < 2; k++) begin
      wrr(8'h1c, k ? 4'h4 : 4'h0);
      in_val = 4'hf;
      repeat (3 * P) @(negedge clk);
      ack(1'b1);
      for (int j = 0; j < 4; j++) begin
        in_val = EV_VAL[k][j];
        cnt = 0;
        repeat (P + 6) begin
          @(negedge clk);
          if (sig === 1'b1) cnt++;
        end
        cmp("ext1 events", EV_EXP[k][j], 12'(cnt));
        cmp("ext1 flag", EV_EXP[k][j], flag);
        rdd(8'h03, got);
        cmp("source level", EV_VAL[k][j], got);
        ack(1'b1);
        cmp("ext1 flag ack", 12'h0, flag);
      end
    end
    $display("test ext1 event done");
    wrap_up();
  end
endmodule
`default_nettype wire

// ---- inc/pmei_pkg.sv ----
// Shared types and the address decode helper of the port block.
// Assumes pmei_regs.svh for all numeric constants.
package pmei_pkg;
  typedef logic [3:0] pmei_nib_t;
  typedef logic [7:0] pmei_addr_t;

  // True when addr falls in the four-word block starting at base
  function automatic logic pmei_blk_hit(input pmei_addr_t addr, input pmei_addr_t base);
    pmei_blk_hit = (addr[7:2] == base[7:2]);
  endfunction
endpackage

// ---- inc/pmei_regs.svh ----
// Register map, field positions, reset values and timing for the port block.
// Assumes an SFR bus with 8-bit addresses and 4-bit data.
`ifndef PMEI_REGS_SVH
`define PMEI_REGS_SVH

// Data registers
`define PMEI_ADDR_BIDIR_A_DATA 8'h00
`define PMEI_ADDR_BIDIR_B_DATA 8'h01
`define PMEI_ADDR_BIDIR_C_DATA 8'h02
`define PMEI_ADDR_IN_PORT_LEVEL 8'h03
`define PMEI_ADDR_OUT_PORT_DATA 8'h04

// Per-bit control registers, four consecutive words each, then the single shared word
`define PMEI_ADDR_BIDIR_A_CFG 8'h10
`define PMEI_ADDR_BIDIR_B_CFG 8'h14
`define PMEI_ADDR_BIDIR_C_CFG 8'h18
`define PMEI_ADDR_SHARED_CFG 8'h1c

// Shared configuration fields
`define PMEI_BIT_PULL_DIR 2
`define PMEI_BIT_OUT_DRIVE 1
`define PMEI_BIT_IN_MODE 0

// Per-bit configuration fields
`define PMEI_BIT_CFG_IE 3
`define PMEI_BIT_CFG_FAST 2
`define PMEI_BIT_CFG_DIR 1
`define PMEI_BIT_CFG_MOD 0

// Reset values
`define PMEI_NIB_RST 4'h0
`define PMEI_BIT_RST 1'b0

// Interrupt vector of the input-port level-change interrupt
`define PMEI_EXT1_VECTOR 12'h032

// Timing
`define PMEI_CLK_PERIOD_NS 4
`define PMEI_TB_PERIOD_NS 15625000
`define PMEI_TB_PERIOD_CYC (`PMEI_TB_PERIOD_NS / `PMEI_CLK_PERIOD_NS)

`endif

// ---- inc/pmei_sfr_if.sv ----
// Link between the port block top and one bidirectional port slice.
// Assumes the top owns bus decode timing and the time-base tick.
`timescale 1ns/1ns
`default_nettype none
interface pmei_sfr_if;
  logic wr;
  pmei_pkg::pmei_addr_t addr;
  pmei_pkg::pmei_nib_t wdata;
  logic tick;
  logic pull_direction_select;
  pmei_pkg::pmei_nib_t rdata;
  logic irq;

  modport ctl (output wr, output addr, output wdata, output tick, output pull_direction_select,
               input rdata, input irq);
  modport port (input wr, input addr, input wdata, input tick, input pull_direction_select,
                output rdata, output irq);
endinterface
`default_nettype wire

// ---- src/pmei_bidir.sv ----
// One 4-bit bidirectional port: data latch, per-bit control words,
// pin synchroniser, read-back mux and per-bit level-change detect.
// Assumes one clock; pins are asynchronous to it.
`include "pmei_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module pmei_bidir #(
  parameter pmei_pkg::pmei_addr_t DATA_ADDR = `PMEI_ADDR_BIDIR_A_DATA,
  parameter pmei_pkg::pmei_addr_t CFG_BASE = `PMEI_ADDR_BIDIR_A_CFG
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Top side
  pmei_sfr_if.port bus,
  // Pins
  input wire logic [3:0] pin_in,
  output logic [3:0] pin_out,
  output logic [3:0] pin_oe_out,
  output logic [3:0] pullup_en_out,
  output logic [3:0] pulldn_en_out
);
  pmei_pkg::pmei_nib_t data_r, data_nxt;
  pmei_pkg::pmei_nib_t cfg_r [4];
  pmei_pkg::pmei_nib_t cfg_nxt [4];
  pmei_pkg::pmei_nib_t sync1_r, sync2_r;
  pmei_pkg::pmei_nib_t samp_r, samp_nxt;
  logic irq_r, irq_nxt;
  pmei_pkg::pmei_nib_t dir, mode, evt;

  always_comb begin
    data_nxt = data_r;
    samp_nxt = samp_r;
    evt = 4'h0;
    if (bus.wr && bus.addr == DATA_ADDR) begin
      data_nxt = bus.wdata;
    end
    for (int i = 0; i < 4; i++) begin
      cfg_nxt[i] = cfg_r[i];
      if (bus.wr && pmei_pkg::pmei_blk_hit(bus.addr, CFG_BASE) && bus.addr[1:0] == 2'(i)) begin
        cfg_nxt[i] = bus.wdata;
      end
      dir[i] = cfg_r[i][`PMEI_BIT_CFG_DIR];
      mode[i] = cfg_r[i][`PMEI_BIT_CFG_MOD];
      // Sample on the 64 Hz tick or every cycle, per bit
      if (cfg_r[i][`PMEI_BIT_CFG_FAST] || bus.tick) begin
        samp_nxt[i] = sync2_r[i];
        evt[i] = cfg_r[i][`PMEI_BIT_CFG_IE] && (sync2_r[i] != samp_r[i]);
      end
    end
    irq_nxt = |evt;
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      data_r <= `PMEI_NIB_RST;
      for (int i = 0; i < 4; i++) begin
        cfg_r[i] <= `PMEI_NIB_RST;
      end
      sync1_r <= `PMEI_NIB_RST;
      sync2_r <= `PMEI_NIB_RST;
      samp_r <= `PMEI_NIB_RST;
      irq_r <= `PMEI_BIT_RST;
    end else begin
      data_r <= data_nxt;
      cfg_r <= cfg_nxt;
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
      samp_r <= samp_nxt;
      irq_r <= irq_nxt;
    end
  end

  // Output bits read back the latch, input bits read the pin
  assign bus.rdata = (dir & data_r) | (~dir & sync2_r);
  assign bus.irq = irq_r;
  assign pin_out = data_r;
  // Open drain only drives while the latch is low
  assign pin_oe_out = dir & (~mode | ~data_r);
  assign pullup_en_out = ~dir & ~mode & {4{~bus.pull_direction_select}};
  assign pulldn_en_out = ~dir & ~mode & {4{bus.pull_direction_select}};
endmodule
`default_nettype wire

// ---- src/pmei_top.sv ----
// Port block: input-only port, output-only port, three bidirectional
// ports, shared configuration word and the input-port level-change interrupt.
// Assumes CPU SFR strobes are synchronous to REF_CLK_IN; pins are not.
`include "pmei_regs.svh"
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - Shared configuration word is 4-bit and write-only; reads return zero.
// - Pull-direction bit: 0 pull-up, 1 pull-down for input port resistors.
// - The same pull-direction bit steers bidirectional resistor inputs too.
// - Reset clears pull-direction, so resistors default to pull-up.
// - Drive bit sets all output-port pins: 0 push-pull, 1 open-drain; reset 0.
// - Input mode bit: 0 resistor input, 1 high impedance; reset 0.
// - Input-port change interrupt sampled only at 64 Hz tick falling edge.
// - Change to interrupt flag delay is at most one 64 Hz period; the code can take one period plus three clock cycles.
// - Interrupt comes from combined input pins; no per-pin source shown.
// - Pull-down: fire on all pins low from all high, any high from all low.
// - Pull-up: fire on any pin low from all high, all high from all low.
// - Accepted interrupt vectors to its fixed address.
// - Each bidirectional bit independently picks its input or output mode.
// - Each bidirectional bit can raise a level-change interrupt.
// - First bidirectional port drives its latch onto pins set as output.
// - First port reads latch for output bits, pin level for input bits.
// - Second bidirectional port behaves the same way.
// - Input level register is read-only and returns pin levels.
// - Output port data register clears to zero at reset.
// - Written port data reaches the pin in the following cycle.
module pmei_top #(
  parameter int unsigned TB_PERIOD_CYC = `PMEI_TB_PERIOD_CYC
) (
  // Clock and reset
  input wire logic REF_CLK_IN,
  input wire logic RST_IN,
  // SFR access
  input wire logic [7:0] SFR_ADDR_IN,
  input wire logic SFR_WR_IN,
  input wire logic SFR_RD_IN,
  input wire logic [3:0] SFR_WDATA_IN,
  output logic [3:0] SFR_RDATA_OUT,
  // Input-only port
  input wire logic [3:0] IN_PORT_PIN_IN,
  output logic IN_PORT_PULLUP_EN_OUT,
  output logic IN_PORT_PULLDN_EN_OUT,
  // Output-only port
  output logic [3:0] OUT_PORT_PIN_OUT,
  output logic [3:0] OUT_PORT_OE_OUT,
  // Bidirectional port A
  input wire logic [3:0] BIDIR_A_PIN_IN,
  output logic [3:0] BIDIR_A_PIN_OUT,
  output logic [3:0] BIDIR_A_OE_OUT,
  output logic [3:0] BIDIR_A_PULLUP_EN_OUT,
  output logic [3:0] BIDIR_A_PULLDN_EN_OUT,
  // Bidirectional port B
  input wire logic [3:0] BIDIR_B_PIN_IN,
  output logic [3:0] BIDIR_B_PIN_OUT,
  output logic [3:0] BIDIR_B_OE_OUT,
  output logic [3:0] BIDIR_B_PULLUP_EN_OUT,
  output logic [3:0] BIDIR_B_PULLDN_EN_OUT,
  // Bidirectional port C
  input wire logic [3:0] BIDIR_C_PIN_IN,
  output logic [3:0] BIDIR_C_PIN_OUT,
  output logic [3:0] BIDIR_C_OE_OUT,
  output logic [3:0] BIDIR_C_PULLUP_EN_OUT,
  output logic [3:0] BIDIR_C_PULLDN_EN_OUT,
  // Interrupts
  input wire logic EXT1_IRQ_ACK_IN,
  input wire logic BIDIR_IRQ_ACK_IN,
  output logic EXT1_IRQ_SIGNAL_OUT,
  output logic EXT1_IRQ_FLAG_OUT,
  output logic [11:0] EXT1_VECTOR_OUT,
  output logic BIDIR_IRQ_FLAG_OUT
);

  // Time base: one-cycle tick per 64 Hz period, taken as its falling edge
  logic [21:0] tb_cnt_r, tb_cnt_nxt;
  logic tick;

  always_comb begin
    tick = (tb_cnt_r == 22'(TB_PERIOD_CYC - 1));
    tb_cnt_nxt = tick ? 22'h000000 : tb_cnt_r + 22'h000001;
  end

  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      tb_cnt_r <= 22'h000000;
    end else begin
      tb_cnt_r <= tb_cnt_nxt;
    end
  end

  // Shared configuration word and output port latch
  logic pull_direction_select_r, pull_direction_select_nxt;
  logic out_port_drive_select_r, out_port_drive_select_nxt;
  logic in_port_input_select_r, in_port_input_select_nxt;
  pmei_pkg::pmei_nib_t out_port_data_r, out_port_data_nxt;

  always_comb begin
    pull_direction_select_nxt = pull_direction_select_r;
    out_port_drive_select_nxt = out_port_drive_select_r;
    in_port_input_select_nxt = in_port_input_select_r;
    out_port_data_nxt = out_port_data_r;
    if (SFR_WR_IN && SFR_ADDR_IN == `PMEI_ADDR_SHARED_CFG) begin
      pull_direction_select_nxt = SFR_WDATA_IN[`PMEI_BIT_PULL_DIR];
      out_port_drive_select_nxt = SFR_WDATA_IN[`PMEI_BIT_OUT_DRIVE];
      in_port_input_select_nxt = SFR_WDATA_IN[`PMEI_BIT_IN_MODE];
    end
    if (SFR_WR_IN && SFR_ADDR_IN == `PMEI_ADDR_OUT_PORT_DATA) begin
      out_port_data_nxt = SFR_WDATA_IN;
    end
  end

  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      pull_direction_select_r <= `PMEI_BIT_RST;
      out_port_drive_select_r <= `PMEI_BIT_RST;
      in_port_input_select_r <= `PMEI_BIT_RST;
      out_port_data_r <= `PMEI_NIB_RST;
    end else begin
      pull_direction_select_r <= pull_direction_select_nxt;
      out_port_drive_select_r <= out_port_drive_select_nxt;
      in_port_input_select_r <= in_port_input_select_nxt;
      out_port_data_r <= out_port_data_nxt;
    end
  end

  // Output port: all four pins share one drive mode
  assign OUT_PORT_PIN_OUT = out_port_data_r;
  assign OUT_PORT_OE_OUT = out_port_drive_select_r ? ~out_port_data_r : 4'hf;

  // Input port resistors, all four pins together
  assign IN_PORT_PULLUP_EN_OUT = ~in_port_input_select_r & ~pull_direction_select_r;
  assign IN_PORT_PULLDN_EN_OUT = ~in_port_input_select_r & pull_direction_select_r;

  // Input port synchroniser and level-change detect
  pmei_pkg::pmei_nib_t in_sync1_r, in_sync2_r;
  logic comb_lvl;
  logic samp_lvl_r, samp_lvl_nxt;
  logic samp_valid_r, samp_valid_nxt;
  logic ext1_irq_signal_r, ext1_irq_signal_nxt;
  logic ext1_irq_flag_r, ext1_irq_flag_nxt;

  always_comb begin
    // Pull-down idles low: watch the OR; pull-up idles high: watch the AND
    comb_lvl = pull_direction_select_r ? |in_sync2_r : &in_sync2_r;
    samp_lvl_nxt = samp_lvl_r;
    samp_valid_nxt = samp_valid_r;
    ext1_irq_signal_nxt = 1'b0;
    if (tick) begin
      samp_lvl_nxt = comb_lvl;
      samp_valid_nxt = 1'b1;
      // First tick only seeds the reference; avoids a spurious event
      ext1_irq_signal_nxt = samp_valid_r && (comb_lvl != samp_lvl_r);
    end
    // Hardware set wins over the acknowledge
    ext1_irq_flag_nxt = ext1_irq_signal_r | (ext1_irq_flag_r & ~EXT1_IRQ_ACK_IN);
  end

  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      in_sync1_r <= `PMEI_NIB_RST;
      in_sync2_r <= `PMEI_NIB_RST;
      samp_lvl_r <= `PMEI_BIT_RST;
      samp_valid_r <= `PMEI_BIT_RST;
      ext1_irq_signal_r <= `PMEI_BIT_RST;
      ext1_irq_flag_r <= `PMEI_BIT_RST;
    end else begin
      in_sync1_r <= IN_PORT_PIN_IN;
      in_sync2_r <= in_sync1_r;
      samp_lvl_r <= samp_lvl_nxt;
      samp_valid_r <= samp_valid_nxt;
      ext1_irq_signal_r <= ext1_irq_signal_nxt;
      ext1_irq_flag_r <= ext1_irq_flag_nxt;
    end
  end

  assign EXT1_IRQ_SIGNAL_OUT = ext1_irq_signal_r;
  assign EXT1_IRQ_FLAG_OUT = ext1_irq_flag_r;

  // Fixed vector held in a register so the output is a flop
  logic [11:0] ext1_vector_r;

  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      ext1_vector_r <= `PMEI_EXT1_VECTOR;
    end else begin
      ext1_vector_r <= `PMEI_EXT1_VECTOR;
    end
  end

  assign EXT1_VECTOR_OUT = ext1_vector_r;

  // Bidirectional port slices
  pmei_sfr_if a_if();
  pmei_sfr_if b_if();
  pmei_sfr_if c_if();

  assign a_if.wr = SFR_WR_IN;
  assign a_if.addr = SFR_ADDR_IN;
  assign a_if.wdata = SFR_WDATA_IN;
  assign a_if.tick = tick;
  assign a_if.pull_direction_select = pull_direction_select_r;
  assign b_if.wr = SFR_WR_IN;
  assign b_if.addr = SFR_ADDR_IN;
  assign b_if.wdata = SFR_WDATA_IN;
  assign b_if.tick = tick;
  assign b_if.pull_direction_select = pull_direction_select_r;
  assign c_if.wr = SFR_WR_IN;
  assign c_if.addr = SFR_ADDR_IN;
  assign c_if.wdata = SFR_WDATA_IN;
  assign c_if.tick = tick;
  assign c_if.pull_direction_select = pull_direction_select_r;

  pmei_bidir #(
    .DATA_ADDR(`PMEI_ADDR_BIDIR_A_DATA),
    .CFG_BASE(`PMEI_ADDR_BIDIR_A_CFG)
  ) u_bidir_a (
    .clk_in(REF_CLK_IN),
    .rst_in(RST_IN),
    .bus(a_if.port),
    .pin_in(BIDIR_A_PIN_IN),
    .pin_out(BIDIR_A_PIN_OUT),
    .pin_oe_out(BIDIR_A_OE_OUT),
    .pullup_en_out(BIDIR_A_PULLUP_EN_OUT),
    .pulldn_en_out(BIDIR_A_PULLDN_EN_OUT)
  );

  pmei_bidir #(
    .DATA_ADDR(`PMEI_ADDR_BIDIR_B_DATA),
    .CFG_BASE(`PMEI_ADDR_BIDIR_B_CFG)
  ) u_bidir_b (
    .clk_in(REF_CLK_IN),
    .rst_in(RST_IN),
    .bus(b_if.port),
    .pin_in(BIDIR_B_PIN_IN),
    .pin_out(BIDIR_B_PIN_OUT),
    .pin_oe_out(BIDIR_B_OE_OUT),
    .pullup_en_out(BIDIR_B_PULLUP_EN_OUT),
    .pulldn_en_out(BIDIR_B_PULLDN_EN_OUT)
  );

  pmei_bidir #(
    .DATA_ADDR(`PMEI_ADDR_BIDIR_C_DATA),
    .CFG_BASE(`PMEI_ADDR_BIDIR_C_CFG)
  ) u_bidir_c (
    .clk_in(REF_CLK_IN),
    .rst_in(RST_IN),
    .bus(c_if.port),
    .pin_in(BIDIR_C_PIN_IN),
    .pin_out(BIDIR_C_PIN_OUT),
    .pin_oe_out(BIDIR_C_OE_OUT),
    .pullup_en_out(BIDIR_C_PULLUP_EN_OUT),
    .pulldn_en_out(BIDIR_C_PULLDN_EN_OUT)
  );

  // Bidirectional level-change flag, set wins over acknowledge
  logic bidir_irq_flag_r, bidir_irq_flag_nxt;

  always_comb begin
    bidir_irq_flag_nxt = a_if.irq | b_if.irq | c_if.irq | (bidir_irq_flag_r & ~BIDIR_IRQ_ACK_IN);
  end

  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      bidir_irq_flag_r <= `PMEI_BIT_RST;
    end else begin
      bidir_irq_flag_r <= bidir_irq_flag_nxt;
    end
  end

  assign BIDIR_IRQ_FLAG_OUT = bidir_irq_flag_r;

  // Read path: data captured on the read strobe and held until the next one
  pmei_pkg::pmei_nib_t rdata_r, rdata_nxt;

  always_comb begin
    rdata_nxt = rdata_r;
    if (SFR_RD_IN) begin
      case (SFR_ADDR_IN)
        `PMEI_ADDR_BIDIR_A_DATA: rdata_nxt = a_if.rdata;
        `PMEI_ADDR_BIDIR_B_DATA: rdata_nxt = b_if.rdata;
        `PMEI_ADDR_BIDIR_C_DATA: rdata_nxt = c_if.rdata;
        `PMEI_ADDR_IN_PORT_LEVEL: rdata_nxt = in_sync2_r;
        `PMEI_ADDR_OUT_PORT_DATA: rdata_nxt = out_port_data_r;
        // Control words are write-only and unmapped space reads zero
        default: rdata_nxt = `PMEI_NIB_RST;
      endcase
    end
  end

  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      rdata_r <= `PMEI_NIB_RST;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign SFR_RDATA_OUT = rdata_r;

endmodule
`default_nettype wire
